//--- rtl/dacc_card_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "dacc_defines.svh"

module dacc_card_ctrl
    import dacc_pkg::*;
#(
    parameter logic [`DACC_CNT_W-1:0] P_DONE_CYC = `DACC_CNT_W'(`DACC_DONE_CYC),
    parameter logic [`DACC_CNT_W-1:0] P_DONE_MIN_CYC = `DACC_CNT_W'(`DACC_DONE_MIN_CYC),
    parameter logic [`DACC_CNT_W-1:0] P_SLOW_CYC = `DACC_CNT_W'(`DACC_SLOW_CYC)
)
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`DACC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_external_trigger_in,
    input wire logic i_external_output_enable,
    input wire logic i_trigger_edge_select,
    input wire logic i_external_data_select,
    input wire logic [`DACC_DAC_W-1:0] i_external_data,
    input wire logic i_slow_trigger_switch,
    input wire logic i_fast_rising_trigger_switch,
    input wire logic i_fast_falling_trigger_switch,
    input wire logic i_external_data_jumper,
    input wire logic i_trigger_polarity_jumper,
    output logic o_busy,
    output logic o_conversion_done,
    output logic o_irq,
    output logic o_card_output_enable,
    output logic [`DACC_DAC_W-1:0] o_dac_code
);

    // --------------------------------------------------------------
    // decode helpers
    // --------------------------------------------------------------
    function automatic logic addr_mapped(input logic [`DACC_ADDR_W-1:0] addr);
        addr_mapped = (addr == `DACC_OFS_FIRST_RANK) || (addr == `DACC_OFS_COMMAND) ||
                      (addr == `DACC_OFS_STATUS) || (addr == `DACC_OFS_SECOND_RANK);
    endfunction

    function automatic logic is_output_cmd(input logic [3:0] code);
        is_output_cmd = (code == `DACC_CMD_WRITE_FIRST) || (code == `DACC_CMD_WRITE_CYCLE) ||
                        (code == `DACC_CMD_OUT_BLOCK) || (code == `DACC_CMD_OUT_INTR) ||
                        (code == `DACC_CMD_OUT_PACED) || (code == `DACC_CMD_OUT_SEQ);
    endfunction

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    dacc_regs_type r;
    dacc_regs_type next_r;
    dacc_pins_type pins;
    logic wr_access;
    logic rd_setup;
    logic [3:0] cmd_code;
    logic [`DACC_WORD_W-1:0] cmd_data;
    logic slow_mode;
    logic fast_mode;
    logic tps_eff;
    logic slt_eff;
    logic trig_rise;
    logic trig_fall;
    logic ext_edge;
    logic host_cycle;
    logic start_cycle;
    logic clear_req;
    logic ack_req;
    logic [`DACC_WORD_W-1:0] status_word;

    assign pins = '{trig: i_external_trigger_in, external_output_enable: i_external_output_enable,
                    trigger_edge_select: i_trigger_edge_select, external_data_select: i_external_data_select,
                    sw_slow: i_slow_trigger_switch, sw_rise: i_fast_rising_trigger_switch,
                    sw_fall: i_fast_falling_trigger_switch, jmp_data: i_external_data_jumper,
                    jmp_pol: i_trigger_polarity_jumper, ext_data: i_external_data};

    // --------------------------------------------------------------
    // combinational decode
    // --------------------------------------------------------------
    assign wr_access = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    assign cmd_code = i_pwdata[`DACC_CMD_MSB:`DACC_CMD_LSB];
    assign cmd_data = i_pwdata[`DACC_DATA_MSB:`DACC_DATA_LSB];
    // only the second stage is read; the first stage only feeds it
    assign slow_mode = r.sync2.sw_slow;
    assign fast_mode = !r.sync2.sw_slow && (r.sync2.sw_rise || r.sync2.sw_fall);
    assign tps_eff = r.sync2.trigger_edge_select && !r.sync2.jmp_pol;
    assign slt_eff = r.sync2.external_data_select && !r.sync2.jmp_data;
    assign trig_rise = r.sync2.trig && !r.trig_prev;
    assign trig_fall = !r.sync2.trig && r.trig_prev;
    // edge select counts only in slow mode; fast mode follows the switches
    assign ext_edge = slow_mode ? (tps_eff ? trig_rise : trig_fall)
                    : fast_mode && ((r.sync2.sw_rise && trig_rise) || (r.sync2.sw_fall && trig_fall));
    // controller cycles are honoured only with the slow switch closed
    assign host_cycle = wr_access && (i_paddr == `DACC_OFS_COMMAND) && slow_mode &&
                        (cmd_code != `DACC_CMD_WRITE_FIRST) &&
                        ((is_output_cmd(cmd_code)) || (cmd_code == `DACC_CMD_CYCLE));
    assign ack_req = wr_access && (i_paddr == `DACC_OFS_COMMAND) && (cmd_code == `DACC_CMD_INTR_ACK);
    assign clear_req = ack_req || (wr_access && (i_paddr == `DACC_OFS_COMMAND) &&
                       (cmd_code == `DACC_CMD_CLEAR_CARD));
    assign status_word = {3'h0, r.sync2.sw_fall, r.sync2.sw_rise, r.sync2.sw_slow, tps_eff, slt_eff,
                          r.sync2.external_output_enable, r.sys_dis, r.card_en, r.irq, r.group, r.armed,
                          r.state == DACC_ST_DONE, r.state == DACC_ST_BUSY};

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.sync1 = pins;
        next_r.sync2 = r.sync1;
        next_r.trig_prev = r.sync2.trig;
        start_cycle = host_cycle;

        // register reads are prepared in the setup phase
        if (rd_setup)
        begin
            case (i_paddr)
                `DACC_OFS_FIRST_RANK: next_r.prdata = {16'h0000, r.first_rank};
                `DACC_OFS_STATUS: next_r.prdata = {16'h0000, status_word};
                `DACC_OFS_SECOND_RANK: next_r.prdata = {20'h0_0000, r.second_rank};
                default: next_r.prdata = `DACC_RST_RDATA;
            endcase
        end

        // clears first so that a set in the same cycle wins
        if (clear_req)
        begin
            next_r.clr_pend = 1'b1;
            next_r.irq = 1'b0;
        end
        if (ack_req)
        begin
            next_r.armed = 1'b0;
            next_r.group = 1'b0;
        end

        if (wr_access && (i_paddr == `DACC_OFS_FIRST_RANK))
        begin
            next_r.first_rank = i_pwdata[`DACC_WORD_W-1:0];
        end
        if (wr_access && (i_paddr == `DACC_OFS_COMMAND))
        begin
            if (is_output_cmd(cmd_code))
            begin
                next_r.first_rank = cmd_data;
            end
            case (cmd_code)
                `DACC_CMD_OUT_BLOCK, `DACC_CMD_OUT_SEQ: next_r.armed = 1'b1;
                `DACC_CMD_OUT_INTR, `DACC_CMD_OUT_PACED:
                begin
                    next_r.armed = 1'b1;
                    next_r.group = 1'b1;
                end
                `DACC_CMD_WRITE_CYCLE: next_r.group = 1'b1;
                `DACC_CMD_ARM: next_r.armed = 1'b1;
                `DACC_CMD_OUT_DISABLE: next_r.sys_dis = 1'b1;
                `DACC_CMD_OUT_ENABLE: next_r.sys_dis = 1'b0;
                default: next_r.sys_dis = r.sys_dis;
            endcase
        end

        case (r.state)
            DACC_ST_IDLE:
            begin
                next_r.cnt = `DACC_RST_CNT;
                if (ext_edge && slow_mode)
                begin
                    next_r.state = DACC_ST_DELAY;
                end
                else if (ext_edge)
                begin
                    start_cycle = 1'b1;
                end
            end
            DACC_ST_DELAY:
            begin
                // slow path holds the trigger 13 us before the cycle
                next_r.cnt = r.cnt + `DACC_CNT_W'(1);
                if (r.cnt == P_SLOW_CYC - `DACC_CNT_W'(1))
                begin
                    start_cycle = 1'b1;
                end
            end
            DACC_ST_BUSY:
            begin
                next_r.cnt = r.cnt + `DACC_CNT_W'(1);
                if (r.cnt == P_DONE_CYC - `DACC_CNT_W'(1))
                begin
                    next_r.state = DACC_ST_DONE;
                    next_r.cnt = `DACC_RST_CNT;
                    next_r.clr_pend = 1'b0;
                    if (r.armed || next_r.armed)
                    begin
                        next_r.irq = 1'b1;
                    end
                end
            end
            DACC_ST_DONE:
            begin
                // an early clear is remembered and served after the minimum
                if (r.cnt != P_DONE_MIN_CYC)
                begin
                    next_r.cnt = r.cnt + `DACC_CNT_W'(1);
                end
                else if (r.clr_pend || clear_req)
                begin
                    next_r.state = DACC_ST_IDLE;
                    next_r.clr_pend = 1'b0;
                end
                if (ext_edge && slow_mode)
                begin
                    next_r.state = DACC_ST_DELAY;
                    next_r.cnt = `DACC_RST_CNT;
                end
                else if (ext_edge)
                begin
                    start_cycle = 1'b1;
                end
            end
            default:
            begin
                next_r.state = DACC_ST_IDLE;
            end
        endcase

        // a new cycle restarts the timer even if one is running
        if (start_cycle)
        begin
            next_r.second_rank = slt_eff ? r.first_rank[`DACC_DAC_W-1:0] : r.sync2.ext_data;
            if (host_cycle && slt_eff && is_output_cmd(cmd_code))
            begin
                next_r.second_rank = cmd_data[`DACC_DAC_W-1:0];
            end
            next_r.card_en = 1'b1;
            next_r.state = DACC_ST_BUSY;
            next_r.cnt = `DACC_RST_CNT;
        end

        next_r.dac_code = `DACC_ZERO_CODE;
        if (next_r.card_en && !next_r.sys_dis && r.sync2.external_output_enable)
        begin
            next_r.dac_code = {~next_r.second_rank[`DACC_DAC_MSB],
                               next_r.second_rank[`DACC_DAC_MSB-1:0]};
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            r <= '{state: DACC_ST_IDLE, sync1: '0, sync2: '0, trig_prev: 1'b0,
                   first_rank: `DACC_RST_WORD, second_rank: `DACC_RST_DAC,
                   dac_code: `DACC_ZERO_CODE, card_en: 1'b0, sys_dis: 1'b0, armed: 1'b0,
                   group: 1'b0, irq: 1'b0, clr_pend: 1'b0, cnt: `DACC_RST_CNT,
                   prdata: `DACC_RST_RDATA};
        end
        else
        begin
            r <= next_r;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign o_prdata = r.prdata;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_mapped(i_paddr);
    assign o_busy = (r.state == DACC_ST_BUSY);
    assign o_conversion_done = (r.state == DACC_ST_DONE);
    assign o_irq = r.irq;
    assign o_card_output_enable = r.card_en;
    assign o_dac_code = r.dac_code;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    logic [`DACC_CNT_W-1:0] busy_len;
    logic [`DACC_CNT_W-1:0] done_len;

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            busy_len <= `DACC_RST_CNT;
            done_len <= `DACC_RST_CNT;
        end
        else
        begin
            // a restart while busy begins a fresh busy period
            busy_len <= start_cycle ? `DACC_RST_CNT : (o_busy ? busy_len + `DACC_CNT_W'(1) : `DACC_RST_CNT);
            done_len <= (o_conversion_done && done_len != P_DONE_MIN_CYC) ? done_len + `DACC_CNT_W'(1)
                      : (o_conversion_done ? done_len : `DACC_RST_CNT);
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    property p_busy_done_excl;
        !(o_busy && o_conversion_done);
    endproperty
    a_busy_done_excl: assert property (p_busy_done_excl) else $error("busy and done high together");

    property p_done_after_busy;
        $rose(o_conversion_done) |-> busy_len == P_DONE_CYC;
    endproperty
    a_done_after_busy: assert property (p_done_after_busy) else $error("done not 6 us after busy");

    property p_done_min;
        $fell(o_conversion_done) && !o_busy && r.state != DACC_ST_DELAY |-> $past(done_len) == P_DONE_MIN_CYC;
    endproperty
    a_done_min: assert property (p_done_min) else $error("done dropped before minimum");

    property p_irq_needs_arm;
        $rose(o_irq) |-> $rose(o_conversion_done) && $past(r.armed || next_r.armed, 1);
    endproperty
    a_irq_needs_arm: assert property (p_irq_needs_arm) else $error("interrupt without arm or done");

    property p_een_zero;
        !r.sync2.external_output_enable |=> o_dac_code == `DACC_ZERO_CODE;
    endproperty
    a_een_zero: assert property (p_een_zero) else $error("output not zero with enable low");

    property p_first_rank_write;
        wr_access && i_paddr == `DACC_OFS_FIRST_RANK |=> r.first_rank == $past(i_pwdata[`DACC_WORD_W-1:0]);
    endproperty
    a_first_rank_write: assert property (p_first_rank_write) else $error("first rank not loaded");

    property p_fast_ignores_host;
        fast_mode && r.state == DACC_ST_IDLE && !ext_edge && wr_access && cmd_code == `DACC_CMD_CYCLE
            |=> !o_busy;
    endproperty
    a_fast_ignores_host: assert property (p_fast_ignores_host) else $error("host cycle in fast mode");

    property p_second_rank_on_cycle;
        !$rose(o_busy) && !(o_busy && busy_len == `DACC_RST_CNT) |-> $stable(r.second_rank);
    endproperty
    a_second_rank_on_cycle: assert property (p_second_rank_on_cycle) else $error("second rank changed");

    property p_cycle_enables;
        $rose(o_busy) |-> r.card_en ##1 o_busy;
    endproperty
    a_cycle_enables: assert property (p_cycle_enables) else $error("card enable not set by cycle");

    c_host_cycle: cover property ($rose(o_busy) ##[1:1000] $rose(o_conversion_done));
    c_irq: cover property ($rose(o_irq));
    c_slow_trigger: cover property (r.state == DACC_ST_DELAY ##1 o_busy);
    c_disable: cover property (r.sys_dis && r.card_en);

endmodule // dacc_card_ctrl

`default_nettype wire

//--- rtl/dacc_defines.svh
`ifndef DACC_DEFINES_SVH
`define DACC_DEFINES_SVH

// --------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------
`define DACC_CLK_MHZ 125
`define DACC_DONE_US 6
`define DACC_DONE_MIN_US 2
`define DACC_SLOW_MIN_US 13
`define DACC_SLOW_MAX_US 20
`define DACC_FAST_MAX_US 7
`define DACC_DONE_CYC (`DACC_DONE_US * `DACC_CLK_MHZ)
`define DACC_DONE_MIN_CYC (`DACC_DONE_MIN_US * `DACC_CLK_MHZ)
`define DACC_SLOW_CYC (`DACC_SLOW_MIN_US * `DACC_CLK_MHZ)
`define DACC_CNT_W 12

// --------------------------------------------------------------
// register map (byte addresses)
// --------------------------------------------------------------
`define DACC_ADDR_W 8
`define DACC_OFS_FIRST_RANK 8'h00
`define DACC_OFS_COMMAND 8'h04
`define DACC_OFS_STATUS 8'h08
`define DACC_OFS_SECOND_RANK 8'h0c

// --------------------------------------------------------------
// command register fields and codes
// --------------------------------------------------------------
`define DACC_CMD_LSB 0
`define DACC_CMD_MSB 3
`define DACC_DATA_LSB 16
`define DACC_DATA_MSB 31
`define DACC_CMD_WRITE_FIRST 4'h1
`define DACC_CMD_WRITE_CYCLE 4'h2
`define DACC_CMD_OUT_BLOCK 4'h3
`define DACC_CMD_OUT_INTR 4'h4
`define DACC_CMD_OUT_PACED 4'h5
`define DACC_CMD_OUT_SEQ 4'h6
`define DACC_CMD_CYCLE 4'h7
`define DACC_CMD_ARM 4'h8
`define DACC_CMD_OUT_DISABLE 4'h9
`define DACC_CMD_OUT_ENABLE 4'ha
`define DACC_CMD_CLEAR_CARD 4'hb
`define DACC_CMD_INTR_ACK 4'hc

// --------------------------------------------------------------
// widths and reset values
// --------------------------------------------------------------
`define DACC_WORD_W 16
`define DACC_DAC_W 12
`define DACC_DAC_MSB 11
`define DACC_ZERO_CODE 12'h800
`define DACC_RST_WORD 16'h0000
`define DACC_RST_DAC 12'h000
`define DACC_RST_CNT 12'h000
`define DACC_RST_RDATA 32'h0000_0000

`endif

//--- rtl/dacc_pkg.sv
`include "dacc_defines.svh"

package dacc_pkg;

    typedef enum logic [3:0]
    {
        DACC_ST_IDLE = 4'h1,
        DACC_ST_DELAY = 4'h2,
        DACC_ST_BUSY = 4'h4,
        DACC_ST_DONE = 4'h8
    } dacc_state_type;

    // all asynchronous pins, synchronised as one vector
    typedef struct packed
    {
        logic trig;
        logic external_output_enable;
        logic trigger_edge_select;
        logic external_data_select;
        logic sw_slow;
        logic sw_rise;
        logic sw_fall;
        logic jmp_data;
        logic jmp_pol;
        logic [`DACC_DAC_W-1:0] ext_data;
    } dacc_pins_type;

    typedef struct packed
    {
        dacc_state_type state;
        dacc_pins_type sync1;
        dacc_pins_type sync2;
        logic trig_prev;
        logic [`DACC_WORD_W-1:0] first_rank;
        logic [`DACC_DAC_W-1:0] second_rank;
        logic [`DACC_DAC_W-1:0] dac_code;
        logic card_en;
        logic sys_dis;
        logic armed;
        logic group;
        logic irq;
        logic clr_pend;
        logic [`DACC_CNT_W-1:0] cnt;
        logic [31:0] prdata;
    } dacc_regs_type;

endpackage

//--- verif/dacc_card_cycle_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dacc_card_cycle_control_bench;
    localparam int P_DONE = 20;
    localparam int P_MIN = 5;
    localparam int P_SLOW = 30;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic sw_slow, sw_rise, sw_fall, jmp_d, jmp_p;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, busy, done, irq, card_output_enable, err, trig, external_output_enable, trigger_edge_select, external_data_select;
    logic [11:0] xdata, dac;
    logic [15:0] d;
    int failures = 0, compares = 0, n;
    always #4 clk = ~clk;
    dacc_card_ctrl #(.P_DONE_CYC(12'h014), .P_DONE_MIN_CYC(12'h005), .P_SLOW_CYC(12'h01e)) uut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_external_trigger_in(trig), .i_external_output_enable(external_output_enable), .i_trigger_edge_select(trigger_edge_select),
        .i_external_data_select(external_data_select), .i_external_data(xdata), .i_slow_trigger_switch(sw_slow),
        .i_fast_rising_trigger_switch(sw_rise), .i_fast_falling_trigger_switch(sw_fall),
        .i_external_data_jumper(jmp_d), .i_trigger_polarity_jumper(jmp_p), .o_busy(busy),
        .o_conversion_done(done), .o_irq(irq), .o_card_output_enable(card_output_enable), .o_dac_code(dac));
    dacc_ext_model ext (.i_core_clk(clk), .o_trig(trig), .o_een(external_output_enable), .o_tps(trigger_edge_select), .o_slt(external_data_select), .o_data(xdata));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // master never assumes a wait count; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [3:0] c, input logic [15:0] wd);
        apb(1'b1, 8'h04, {wd, 12'h000, c});
    endtask
    // s: 0 busy high, 1 done high, 2 done low; n = cycles taken, 100 if never
    task automatic wait_for(input int s);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (n < 100 && ((s == 0) ? busy : (s == 1) ? done : !done) !== 1'b1);
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // on-card switches and jumpers: slow, rise, fall, data jumper, polarity jumper
    task automatic cfg(input logic [4:0] v);
        @(posedge clk);
        {sw_slow, sw_rise, sw_fall, jmp_d, jmp_p} <= v;
    endtask
    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures++;
        tally_and_finish;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        cfg(5'b10000);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("reset dac", {20'h0, dac}, 32'h800);
        chk("reset flags", {28'h0, busy, done, irq, card_output_enable}, 32'h0);
        apb(1'b1, 8'h00, 32'hffff_a5c3);
        apb(1'b0, 8'h00, 32'h0);
        chk("first rank", rd, 32'ha5c3);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        $display("test reset and bus done");
        cmd(4'h1, 16'h1abc);
        wait_for(0);
        chk("load only", n, 32'd100);
        apb(1'b0, 8'h00, 32'h0);
        chk("load value", rd, 32'h1abc);
        cmd(4'h7, 16'h0);
        wait_for(0);
        chk("busy lag", n, 32'h1);
        chk("dac on cycle", {card_output_enable, 19'h0, dac}, {1'b1, 19'h0, 12'h2bc});
        wait_for(1);
        chk("done time", n + 1, P_DONE);
        chk("busy drop", {30'h0, busy, irq}, 32'h0);
        cmd(4'hb, 16'h0);
        wait_for(2);
        chk("done min", 32'(n + 2 >= P_MIN && n + 2 <= P_MIN + 1), 32'h1);
        $display("test host cycle done");
        for (int c = 2; c < 7; c++)
        begin
            d = {4'hf, ~c[3:0], 8'h3c};
            cmd(c[3:0], d);
            apb(1'b0, 8'h08, 32'h0);
            chk("arm group", rd & 32'hc, {28'h0, 1'(c == 2 || c == 4 || c == 5), 1'(c > 2), 2'h0});
            chk("dac", {20'h0, dac}, {20'h0, ~d[11], d[10:0]});
            wait_for(1);
            chk("irq", {31'h0, irq}, {31'h0, 1'(c > 2)});
            cmd(4'hc, 16'h0);
            wait_for(2);
            apb(1'b0, 8'h08, 32'h0);
            chk("ack", rd & 32'h1e, 32'h0);
        end
        $display("test output commands done");
        cmd(4'h9, 16'h0);
        settle(2);
        chk("disable", {20'h0, dac}, 32'h800);
        cmd(4'ha, 16'h0);
        settle(2);
        chk("enable", {20'h0, dac}, {20'h0, ~d[11], d[10:0]});
        ext.drive(1'b0, 1'b1, 1'b1, 12'h000);
        settle(4);
        chk("een low", {20'h0, dac}, 32'h800);
        ext.drive(1'b1, 1'b1, 1'b0, 12'h7ff);
        settle(4);
        chk("een high", {20'h0, dac}, {20'h0, ~d[11], d[10:0]});
        cmd(4'h7, 16'h0);
        wait_for(0);
        chk("ext data", {20'h0, dac}, 32'hfff);
        ext.drive(1'b1, 1'b1, 1'b1, 12'h801);
        cfg(5'b10010);
        settle(4);
        cmd(4'h7, 16'h0);
        settle(2);
        apb(1'b0, 8'h0c, 32'h0);
        chk("jumper data", rd, 32'h801);
        cfg(5'b10000);
        $display("test output enable and data source done");
        wait_for(1);
        ext.edge_to(1'b1);
        wait_for(0);
        chk("slow rise", 32'(n >= P_SLOW && n <= 50), 32'h1);
        ext.drive(1'b1, 1'b0, 1'b1, 12'h000);
        wait_for(1);
        ext.edge_to(1'b0);
        wait_for(0);
        chk("slow fall", 32'(n >= P_SLOW && n <= 50), 32'h1);
        wait_for(1);
        ext.edge_to(1'b1);
        wait_for(0);
        chk("wrong edge", n, 32'd100);
        // polarity jumper forces the falling edge even with edge select high
        ext.drive(1'b1, 1'b1, 1'b1, 12'h000);
        cfg(5'b10001);
        ext.edge_to(1'b0);
        wait_for(0);
        chk("jumper fall", 32'(n >= P_SLOW && n <= 50), 32'h1);
        wait_for(1);
        cmd(4'hb, 16'h0);
        wait_for(2);
        ext.edge_to(1'b1);
        $display("test slow trigger done");
        cfg(5'b01000);
        ext.edge_to(1'b0);
        settle(4);
        cmd(4'h7, 16'h0);
        wait_for(0);
        chk("host ignored", n, 32'd100);
        ext.edge_to(1'b1);
        wait_for(0);
        chk("fast rise", 32'(n <= 16), 32'h1);
        cfg(5'b00100);
        wait_for(1);
        ext.edge_to(1'b0);
        wait_for(0);
        chk("fast fall", 32'(n <= 16), 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk("status cfg", rd & 32'h1c00, 32'h1000);
        $display("test fast trigger done");
        tally_and_finish;
    end
endmodule // dacc_card_cycle_control_bench
`default_nettype wire

//--- verif/dacc_ext_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "dacc_defines.svh"
module dacc_ext_model
(
    input wire logic i_core_clk,
    output logic o_trig,
    output logic o_een,
    output logic o_tps,
    output logic o_slt,
    output logic [`DACC_DAC_W-1:0] o_data
);
    // ----------------------------------------
    // customer equipment on the edge connector
    // ----------------------------------------
    // pulled-up pins idle high, as if left open
    initial {o_trig, o_een, o_tps, o_slt, o_data} = 16'h7000;
    // parallel data is twos complement, msb on line 11
    task automatic drive(input logic external_output_enable, input logic trigger_edge_select, input logic external_data_select, input logic [11:0] d);
        @(posedge i_core_clk);
        o_een <= external_output_enable;
        o_tps <= trigger_edge_select;
        o_slt <= external_data_select;
        o_data <= d;
    endtask
    // one trigger transition, used by the slow and fast trigger tests
    task automatic edge_to(input logic lvl);
        @(posedge i_core_clk);
        o_trig <= lvl;
    endtask
endmodule // dacc_ext_model
`default_nettype wire
